/* src/fcu_pkg.sv */
package fcu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam int          ADDR_W         = 12;
  localparam logic [11:0] OFS_CTRL       = 12'h000;
  localparam logic [11:0] OFS_LENGTH     = 12'h004;
  localparam logic [11:0] OFS_PRESHARE   = 12'h008;
  localparam logic [11:0] OFS_ADD_CH     = 12'h00c;
  localparam logic [11:0] OFS_TRIG_MASK  = 12'h010;
  localparam logic [11:0] OFS_STATUS     = 12'h014;
  localparam logic [11:0] OFS_LEN_LIMIT  = 12'h018;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h01c;
  localparam logic [11:0] OFS_IRQ_MASK   = 12'h020;
  localparam logic [11:0] OFS_READ_SEL   = 12'h024;
  localparam logic [11:0] OFS_READ_DATA  = 12'h028;
  localparam logic [11:0] OFS_READ_STAMP = 12'h02c;

  // Field positions
  localparam int CTRL_EN      = 0;
  localparam int CTRL_OVW     = 1;
  localparam int CTRL_RATE    = 2;
  localparam int CTRL_MANUAL  = 8;
  localparam int CTRL_CLEAR_CHANNELS   = 9;
  localparam int ST_COUNT_LSB = 8;
  localparam int ST_MAX_LSB   = 16;
  localparam int ST_CH_LSB    = 24;
  localparam int SEL_IDX_LSB  = 16;
  localparam int IRQ_DONE     = 0;
  localparam int IRQ_TRIG     = 1;
  localparam int IRQ_REJECT   = 2;
  localparam int IRQ_ERASED   = 3;
  localparam int IRQ_W        = 4;

  // Sizes
  localparam int MAX_RECORDS  = 24;
  localparam int MAX_CHANNELS = 12;
  localparam int SAMPLE_W     = 16;
  localparam int NUM_STAGES   = 8;
  localparam int NUM_DISCRETE = 8;
  localparam int NUM_ARC      = 2;
  localparam int NUM_DOUT     = 16;
  localparam int NUM_LOGIC    = 4;
  localparam int NUM_GOOSE    = 4;
  localparam int NUM_MEAS     = 8;
  localparam int NUM_CALC     = 8;
  localparam int CODE_W       = 5;
  localparam int CODE_CALC    = 8;
  localparam int CODE_DIN     = 16;
  localparam int CODE_DOUT    = 17;
  localparam int NUM_CODES    = 18;

  // Timing and reset values
  localparam int          PCT_MAX          = 100;
  localparam int          US_PER_MS        = 1000;
  localparam int          CLK_PERIOD_NS    = 10;
  localparam int          MS_NS            = 1000000;
  localparam int          MS_CYCLES        = MS_NS / CLK_PERIOD_NS;
  localparam int          NOMINAL_CYCLE_US = 20000;
  localparam int          SPC_HI           = 32;
  localparam int          SPC_MID          = 16;
  localparam int          SPC_LO           = 8;
  localparam logic [31:0] LENGTH_RESET     = 32'h0000_03e8;
  localparam logic [6:0]  PRESHARE_RESET   = 7'h32;

  typedef enum logic [3:0] {
    RATE_W32, RATE_W16, RATE_W8, RATE_10MS, RATE_20MS, RATE_200MS,
    RATE_1S, RATE_5S, RATE_10S, RATE_15S, RATE_30S, RATE_1MIN
  } fcu_rate_e;

  typedef enum logic [1:0] {ST_INACTIVE, ST_ARMED, ST_TRIGGERED, ST_FULL} fcu_state_e;

  typedef struct packed {
    logic [NUM_GOOSE-1:0]    goose;
    logic [NUM_LOGIC-1:0]    logicOut;
    logic [NUM_DISCRETE-1:0] din;
    logic [NUM_STAGES-1:0]   trip;
    logic [NUM_STAGES-1:0]   start;
  } fcu_trig_s;

  typedef struct packed {
    logic [NUM_CALC-1:0][SAMPLE_W-1:0] calc;
    logic [NUM_MEAS-1:0][SAMPLE_W-1:0] rms;
    logic [NUM_MEAS-1:0][SAMPLE_W-1:0] wave;
  } fcu_meas_s;

  typedef struct packed {
    logic [NUM_DOUT-1:0]     dout;
    logic [NUM_ARC-1:0]      arc;
    logic [NUM_DISCRETE-1:0] din;
  } fcu_digital_s;

  // Sample period per rate; waveform rates assume nominal frequency
  function automatic logic [31:0] fcu_period_us(input fcu_rate_e r);
    case (r)
      RATE_W32:   return 32'(NOMINAL_CYCLE_US / SPC_HI);
      RATE_W16:   return 32'(NOMINAL_CYCLE_US / SPC_MID);
      RATE_W8:    return 32'(NOMINAL_CYCLE_US / SPC_LO);
      RATE_10MS:  return 32'd10000;
      RATE_20MS:  return 32'd20000;
      RATE_200MS: return 32'd200000;
      RATE_1S:    return 32'd1000000;
      RATE_5S:    return 32'd5000000;
      RATE_10S:   return 32'd10000000;
      RATE_15S:   return 32'd15000000;
      RATE_30S:   return 32'd30000000;
      default:    return 32'd60000000;
    endcase
  endfunction : fcu_period_us

  // Calculated channels need a period slower than 10 ms
  function automatic logic fcu_is_fast(input fcu_rate_e r);
    return (r == RATE_W32) || (r == RATE_W16) || (r == RATE_W8) || (r == RATE_10MS);
  endfunction : fcu_is_fast

endpackage : fcu_pkg

/* src/fcu_fault_capture_unit.sv */
`timescale 1ns/1ns
`default_nettype none
module fcu_fault_capture_unit
  import fcu_pkg::*;
#(
  parameter int MEM_WORDS   = 4096,
  parameter int MS_CYCLES_P = MS_CYCLES
)(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Relay signal sources
  input  wire fcu_trig_s          trigSrc,
  input  wire fcu_meas_s          meas,
  input  wire fcu_digital_s       digital,
  input  wire logic [NUM_STAGES-1:0] stageEnable,
  input  wire logic [NUM_CODES-1:0]  chanAvail,
  input  wire logic               sampleTick,
  input  wire logic [31:0]        timeNow,
  // Interrupt
  output logic                    irq
);

  localparam int AW = $clog2(MEM_WORDS);
  localparam int PW = $clog2(MS_CYCLES_P + 1);

  typedef struct packed {
    logic                                 ctrlEnable;
    logic                                 modeOverwrite;
    fcu_rate_e                            rate;
    logic [31:0]                          lengthMs;
    logic [6:0]                           preShare;
    logic [31:0]                          trigMask;
    logic [MAX_CHANNELS-1:0][CODE_W-1:0]  chanList;
    logic [3:0]                           chanCount;
    logic [IRQ_W-1:0]                     irqStatus;
    logic [IRQ_W-1:0]                     irqMask;
    logic [4:0]                           readRec;
    logic [15:0]                          readIdx;
    logic                                 pready;
    logic                                 pslverr;
    logic [31:0]                          prdata;
    logic                                 irq;
    fcu_state_e                           state;
    logic [31:0]                          prevTrig;
    logic [NUM_STAGES-1:0]                prevStageEn;
    logic [1:0]                           divCnt;
    logic [PW-1:0]                        msPresc;
    logic [15:0]                          msCount;
    logic                                 burst;
    logic [3:0]                           burstIdx;
    logic [AW-1:0]                        pos;
    logic                                 wrapped;
    logic [31:0]                          postLeft;
    logic [4:0]                           curSlot;
    logic [4:0]                           oldest;
    logic [4:0]                           recCount;
    logic [MAX_RECORDS-1:0][AW-1:0]       startOff;
    logic [MAX_RECORDS-1:0][31:0]         stamp;
    logic [MEM_WORDS-1:0][SAMPLE_W-1:0]   mem;
  } fcu_regs_s;

  fcu_regs_s        s_ff;
  fcu_regs_s        nxt_s;
  logic [63:0]      perUs;
  logic [63:0]      need;
  logic [63:0]      recWords;
  logic [63:0]      quot;
  logic [4:0]       maxRec;
  logic [63:0]      preS;
  logic [63:0]      chW;
  logic [31:0]      lenLimit;
  logic             active;
  logic             take;
  logic             msTick;
  logic             erase;
  logic             manual;
  logic             trigHit;
  logic [IRQ_W-1:0] irqSet;
  logic [IRQ_W-1:0] irqClr;
  logic [63:0]      rdSlot;
  logic [63:0]      rdOff;
  logic [AW-1:0]    rdAddr;
  logic             rdOk;
  logic [63:0]      wrAddr;
  logic [CODE_W-1:0] code;
  logic [SAMPLE_W-1:0] chanVal;
  logic [31:0]      rdVal;
  logic             mapped;

  // Single subtraction modulo, enough when a < 2 * lim
  function automatic logic [63:0] wrapAt(input logic [63:0] a, input logic [63:0] lim);
    return (a >= lim) ? a - lim : a;
  endfunction : wrapAt

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    nxt_s   = s_ff;
    irqSet  = '0;
    irqClr  = '0;
    erase   = 1'b0;
    manual  = 1'b0;
    rdVal   = '0;
    mapped  = 1'b1;
    chanVal = '0;
    code    = '0;
    wrAddr  = '0;

    // Layout derived from configuration
    perUs    = 64'(fcu_period_us(s_ff.rate));
    need     = (64'(s_ff.lengthMs) * US_PER_MS + perUs - 64'h1) / perUs;
    if (need == 64'h0)
      need = 64'h1;
    recWords = need * 64'(s_ff.chanCount);
    quot     = (recWords == 64'h0) ? 64'h0 : 64'(MEM_WORDS) / recWords;
    maxRec   = (quot > MAX_RECORDS) ? 5'(MAX_RECORDS) : quot[4:0];
    preS     = need * 64'(s_ff.preShare) / PCT_MAX;
    chW      = (s_ff.chanCount == 4'h0) ? 64'h1 : 64'(s_ff.chanCount);
    lenLimit = 32'((64'(MEM_WORDS) / chW) * perUs / US_PER_MS);
    active   = s_ff.ctrlEnable && (maxRec != 5'h0);

    // Sample strobes: waveform from the cycle tick, averaged from a ms timer
    nxt_s.msPresc = (s_ff.msPresc == PW'(MS_CYCLES_P - 1)) ? '0 : s_ff.msPresc + PW'(1);
    msTick        = (s_ff.msPresc == PW'(MS_CYCLES_P - 1));
    if (sampleTick)
      nxt_s.divCnt = s_ff.divCnt + 2'h1;
    take = 1'b0;
    case (s_ff.rate)
      RATE_W32: take = sampleTick;
      RATE_W16: take = sampleTick && !s_ff.divCnt[0];
      RATE_W8:  take = sampleTick && (s_ff.divCnt == 2'h0);
      default:
      begin
        if (msTick)
        begin
          take = (32'(s_ff.msCount) + 32'h1 >= 32'(perUs / US_PER_MS));
          nxt_s.msCount = take ? 16'h0 : s_ff.msCount + 16'h1;
        end
      end
    endcase

    // Read decode, answered in the access phase
    nxt_s.pready  = 1'b0;
    nxt_s.pslverr = 1'b0;
    rdSlot = wrapAt(64'(s_ff.oldest) + 64'(s_ff.readRec), 64'(maxRec));
    rdOff  = wrapAt(64'(s_ff.startOff[rdSlot[4:0]]) + 64'(s_ff.readIdx), recWords);
    rdAddr = AW'(rdSlot * recWords + rdOff);
    rdOk   = (s_ff.readRec < s_ff.recCount) && (64'(s_ff.readIdx) < recWords);
    case (paddr)
      OFS_CTRL:       rdVal = {26'h0, s_ff.rate, s_ff.modeOverwrite, s_ff.ctrlEnable};
      OFS_LENGTH:     rdVal = s_ff.lengthMs;
      OFS_PRESHARE:   rdVal = {25'h0, s_ff.preShare};
      OFS_ADD_CH:     rdVal = '0;
      OFS_TRIG_MASK:  rdVal = s_ff.trigMask;
      OFS_STATUS:     rdVal = {4'h0, s_ff.chanCount, 3'h0, maxRec, 3'h0, s_ff.recCount,
                               6'h0, s_ff.state};
      OFS_LEN_LIMIT:  rdVal = lenLimit;
      OFS_IRQ_STATUS: rdVal = {28'h0, s_ff.irqStatus};
      OFS_IRQ_MASK:   rdVal = {28'h0, s_ff.irqMask};
      OFS_READ_SEL:   rdVal = {s_ff.readIdx, 11'h0, s_ff.readRec};
      OFS_READ_DATA:  rdVal = rdOk ? {16'h0, s_ff.mem[rdAddr]} : '0;
      OFS_READ_STAMP: rdVal = rdOk ? s_ff.stamp[rdSlot[4:0]] : '0;
      default:        mapped = 1'b0;
    endcase
    if (psel && !penable)
    begin
      nxt_s.pready  = 1'b1;
      nxt_s.pslverr = !mapped;
      nxt_s.prdata  = mapped ? rdVal : '0;
    end

    // Register writes take effect at the completing access edge
    if (psel && penable && s_ff.pready && pwrite)
    begin
      case (paddr)
        OFS_CTRL:
        begin
          nxt_s.ctrlEnable    = pwdata[CTRL_EN];
          nxt_s.modeOverwrite = pwdata[CTRL_OVW];
          nxt_s.rate          = fcu_rate_e'(pwdata[CTRL_RATE +: 4]);
          // Layout depends on the rate, so old records cannot be kept
          if (pwdata[CTRL_RATE +: 4] != s_ff.rate)
            erase = 1'b1;
          manual = pwdata[CTRL_MANUAL];
          if (pwdata[CTRL_CLEAR_CHANNELS])
          begin
            nxt_s.chanCount = 4'h0;
            erase           = 1'b1;
          end
        end
        OFS_LENGTH:
        begin
          nxt_s.lengthMs = pwdata;
          erase          = (pwdata != s_ff.lengthMs);
        end
        OFS_PRESHARE:
          nxt_s.preShare = (pwdata > PCT_MAX) ? 7'(PCT_MAX) : pwdata[6:0];
        OFS_ADD_CH:
        begin
          // Unavailable, fast-rate calculated or overflowing entries are dropped
          if ((s_ff.chanCount < 4'(MAX_CHANNELS)) && (pwdata < NUM_CODES)
              && chanAvail[pwdata[CODE_W-1:0]]
              && !(pwdata >= CODE_CALC && pwdata < CODE_DIN && fcu_is_fast(s_ff.rate)))
          begin
            nxt_s.chanList[s_ff.chanCount] = pwdata[CODE_W-1:0];
            nxt_s.chanCount                = s_ff.chanCount + 4'h1;
            erase                          = 1'b1;
          end
          else
            irqSet[IRQ_REJECT] = 1'b1;
        end
        OFS_TRIG_MASK:  nxt_s.trigMask = pwdata;
        OFS_IRQ_STATUS: irqClr = pwdata[IRQ_W-1:0];
        OFS_IRQ_MASK:   nxt_s.irqMask = pwdata[IRQ_W-1:0];
        OFS_READ_SEL:
        begin
          nxt_s.readRec = pwdata[4:0];
          nxt_s.readIdx = pwdata[SEL_IDX_LSB +: 16];
        end
        default:
          erase = erase;
      endcase
    end

    // Protection stage toggling wipes the store
    nxt_s.prevStageEn = stageEnable;
    if (stageEnable != s_ff.prevStageEn)
      erase = 1'b1;

    // Rising edge of any source routed to the trigger column
    nxt_s.prevTrig = trigSrc;
    trigHit = |(trigSrc & ~s_ff.prevTrig & s_ff.trigMask) || manual;

    // Sample burst: one channel word per clock, live source values
    if (s_ff.burst)
    begin
      code = s_ff.chanList[s_ff.burstIdx];
      if (code == 5'(CODE_DIN))
        chanVal = SAMPLE_W'({digital.arc, digital.din});
      else if (code == 5'(CODE_DOUT))
        chanVal = digital.dout;
      else if (code >= 5'(CODE_CALC))
        chanVal = fcu_is_fast(s_ff.rate) ? '0 : meas.calc[code - 5'(CODE_CALC)];
      else if (fcu_is_fast(s_ff.rate) && s_ff.rate != RATE_10MS)
        chanVal = meas.wave[code];
      else
        chanVal = meas.rms[code];
      wrAddr = 64'(s_ff.curSlot) * recWords + 64'(s_ff.pos);
      nxt_s.mem[AW'(wrAddr)] = chanVal;
      nxt_s.burstIdx = s_ff.burstIdx + 4'h1;
      nxt_s.pos      = s_ff.pos + AW'(1);
      if (64'(s_ff.pos) + 64'h1 >= recWords)
      begin
        nxt_s.pos     = '0;
        nxt_s.wrapped = 1'b1;
      end
      if (s_ff.burstIdx + 4'h1 >= s_ff.chanCount)
      begin
        nxt_s.burst = 1'b0;
        if (s_ff.state == ST_TRIGGERED && s_ff.postLeft != 32'h0)
          nxt_s.postLeft = s_ff.postLeft - 32'h1;
      end
    end
    else if (take && (s_ff.state == ST_ARMED || s_ff.state == ST_TRIGGERED))
    begin
      nxt_s.burst    = 1'b1;
      nxt_s.burstIdx = 4'h0;
    end

    // Recorder sequence
    case (s_ff.state)
      ST_INACTIVE:
      begin
        if (active)
        begin
          nxt_s.pos     = '0;
          nxt_s.wrapped = 1'b0;
          nxt_s.burst   = 1'b0;
          nxt_s.state   = ST_ARMED;
          if (s_ff.recCount >= maxRec)
          begin
            if (s_ff.modeOverwrite)
            begin
              // Oldest record is consumed as soon as its slot is reused
              nxt_s.curSlot  = s_ff.oldest;
              nxt_s.oldest   = 5'(wrapAt(64'(s_ff.oldest) + 64'h1, 64'(maxRec)));
              nxt_s.recCount = s_ff.recCount - 5'h1;
            end
            else
              nxt_s.state = ST_FULL;
          end
          else
            nxt_s.curSlot = 5'(wrapAt(64'(s_ff.oldest) + 64'(s_ff.recCount), 64'(maxRec)));
        end
      end
      ST_ARMED:
      begin
        if (trigHit)
        begin
          nxt_s.postLeft = 32'(need - preS);
          nxt_s.stamp[s_ff.curSlot] = timeNow;
          nxt_s.state    = ST_TRIGGERED;
          irqSet[IRQ_TRIG] = 1'b1;
        end
      end
      ST_TRIGGERED:
      begin
        if (nxt_s.postLeft == 32'h0 && !nxt_s.burst)
        begin
          nxt_s.startOff[s_ff.curSlot] = nxt_s.wrapped ? nxt_s.pos : '0;
          nxt_s.recCount   = s_ff.recCount + 5'h1;
          nxt_s.state      = ST_INACTIVE;
          irqSet[IRQ_DONE] = 1'b1;
        end
      end
      ST_FULL:
      begin
        if (trigHit)
          irqSet[IRQ_REJECT] = 1'b1;
        if (s_ff.modeOverwrite)
          nxt_s.state = ST_INACTIVE;
      end
      default:
        nxt_s.state = ST_INACTIVE;
    endcase
    if (!active && s_ff.state != ST_INACTIVE)
    begin
      nxt_s.state = ST_INACTIVE;
      nxt_s.burst = 1'b0;
    end

    // Erase overrides any capture in flight
    if (erase)
    begin
      nxt_s.recCount     = 5'h0;
      nxt_s.oldest       = 5'h0;
      nxt_s.curSlot      = 5'h0;
      nxt_s.burst        = 1'b0;
      nxt_s.state        = ST_INACTIVE;
      irqSet[IRQ_ERASED] = 1'b1;
    end

    // Sticky events: a set in the clearing cycle survives
    nxt_s.irqStatus = (s_ff.irqStatus & ~irqClr) | irqSet;
    nxt_s.irq       = |(nxt_s.irqStatus & nxt_s.irqMask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_ff          <= '0;
      s_ff.rate     <= RATE_W32;
      s_ff.state    <= ST_INACTIVE;
      s_ff.lengthMs <= LENGTH_RESET;
      s_ff.preShare <= PRESHARE_RESET;
    end
    else
      s_ff <= nxt_s;
  end

  // Outputs straight from the state register
  assign prdata  = s_ff.prdata;
  assign pready  = s_ff.pready;
  assign pslverr = s_ff.pslverr;
  assign irq     = s_ff.irq;

endmodule : fcu_fault_capture_unit
`default_nettype wire

/* tb/fcu_relay_model.sv */
`timescale 1ns/1ns
`default_nettype none
module fcu_relay_model
  import fcu_pkg::*;
#(
  parameter int TICK_DIV = 4
)(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Relay signal sources
  output wire fcu_meas_s    meas,
  output wire fcu_digital_s digital,
  output logic              sampleTick,
  output logic [31:0]       timeNow
);
  logic [7:0] divCnt;

  // One constant per source kind, so a stored word shows which source it came from
  assign meas    = {{NUM_CALC{16'h0c0c}}, {NUM_MEAS{16'h1e0f}}, {NUM_MEAS{16'h5a3c}}};
  assign digital = {16'h00ff, 2'b11, 8'ha5};

  // Tick once per TICK_DIV cycles; the stamp source counts cycles
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      divCnt     <= 8'h0;
      sampleTick <= 1'b0;
      timeNow    <= 32'h1;
    end
    else
    begin
      divCnt     <= (divCnt == 8'(TICK_DIV - 1)) ? 8'h0 : divCnt + 8'h1;
      sampleTick <= (divCnt == 8'h0);
      timeNow    <= timeNow + 32'h1;
    end
  end
endmodule : fcu_relay_model
`default_nettype wire

/* tb/fcu_capture_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module fcu_capture_checker
  import fcu_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst_b,
  // APB and interrupt
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Completed read of one register
  sequence rd_at(logic [11:0] a);
    psel && penable && pready && !pwrite && paddr == a;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  chk_ready_next: assert property (psel && !penable |=> penable && pready)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_err_map: assert property (pready |-> pslverr == (paddr > OFS_READ_STAMP))
    else $error("error flag wrong for address");
  chk_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  chk_count_cap: assert property (rd_at(OFS_STATUS) |-> prdata[12:8] <= prdata[20:16] && prdata[20:16] <= MAX_RECORDS)
    else $error("record count above limit");
  chk_chan_cap: assert property (rd_at(OFS_STATUS) |-> prdata[27:24] <= MAX_CHANNELS)
    else $error("channel count above limit");
  chk_full_count: assert property (rd_at(OFS_STATUS) ##0 prdata[1:0] == 2'd3 |-> prdata[12:8] == prdata[20:16])
    else $error("full state with free room");
  chk_share_clamp: assert property (rd_at(OFS_PRESHARE) |-> prdata <= PCT_MAX)
    else $error("pre-trigger share above limit");
  chk_ctrl_bits: assert property (rd_at(OFS_CTRL) |-> prdata[31:6] == 26'h0)
    else $error("control reads back stray bits");
  chk_irq_masked: assert property (psel && penable && pready && pwrite && paddr == OFS_IRQ_MASK && pwdata == 32'h0
    |-> ##2 !irq) else $error("irq high with all masked");

  // Main scenarios reached
  cov_refused: cover property (pslverr);
  cov_irq: cover property ($rose(irq));
  cov_full: cover property (rd_at(OFS_STATUS) ##0 prdata[1:0] == 2'd3);
endmodule : fcu_capture_checker
`default_nettype wire

/* tb/fcu_fault_capture_unit_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module fcu_fault_capture_unit_bench
  import fcu_pkg::*;
;
  localparam int MEMW = 64;
  localparam int LEN  = 5;
  localparam int PER  = NOMINAL_CYCLE_US / SPC_HI;
  localparam int NEED = (LEN * US_PER_MS + PER - 1) / PER;
  localparam int MAXR = MEMW / (2 * NEED);
  localparam int LIM  = (MEMW / 2) * PER / US_PER_MS;
  logic                  clk, rst_b, psel, penable, pwrite, pready, pslverr, irq, tick, err;
  logic [ADDR_W-1:0]     paddr;
  logic [31:0]           pwdata, prdata, tNow, rdv, stamp;
  logic [NUM_STAGES-1:0] stageEn;
  logic [NUM_CODES-1:0]  avail;
  fcu_trig_s             trig;
  fcu_meas_s             meas;
  fcu_digital_s          dig;
  int                    badCount, cmpCount;
  int                    srcBit[5] = '{0, 8, 16, 24, 28};

  fcu_fault_capture_unit #(.MEM_WORDS(MEMW), .MS_CYCLES_P(10)) i_dut (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .trigSrc(trig),
    .meas(meas), .digital(dig), .stageEnable(stageEn), .chanAvail(avail), .sampleTick(tick),
    .timeNow(tNow), .irq(irq));
  fcu_relay_model #(.TICK_DIV(4)) i_src (.clk(clk), .rst_b(rst_b), .meas(meas), .digital(dig),
    .sampleTick(tick), .timeNow(tNow));

  ////////////////////////////////////////////////////////////////////////////
  // One APB transfer; the request stands until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmpCount++;
    if (g !== e)
    begin
      $display("unexpected %s: expected %h seen %h", n, e, g);
      badCount++;
    end
  endtask : chk

  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("register %h", a), e, rdv & m);
  endtask : rd

  function automatic logic [31:0] st(input int c, input int m, input int n, input int s);
    return 32'((c << ST_CH_LSB) | (m << ST_MAX_LSB) | (n << ST_COUNT_LSB) | s);
  endfunction : st

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////
  // Free-running 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cut a hang short far past the expected run length
  initial
  begin
    repeat (20000) @(posedge clk);
    badCount++;
    summarize();
  end

  // Main sequence; code 1 is reported unavailable throughout
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    trig    = '0;
    stageEn = '0;
    avail   = ~NUM_CODES'(2);
    rst_b   = 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rd(OFS_CTRL, '1, 32'h0);
    rd(OFS_LENGTH, '1, LENGTH_RESET);
    rd(OFS_PRESHARE, '1, 32'(PRESHARE_RESET));
    rd(OFS_STATUS, '1, 32'h0);
    rd(12'h030, '1, 32'h0);
    chk("refused flag", 32'h1, 32'(err));
    $display("test reset done");
    for (int c = 0; c < NUM_CODES; c++)
      apb(1'b1, OFS_ADD_CH, 32'(c));
    rd(OFS_STATUS, 32'h0f00_0000, st(9, 0, 0, 0));
    rd(OFS_IRQ_STATUS, 32'h4, 32'h4);
    chk("masked irq", 32'h0, 32'(irq));
    apb(1'b1, OFS_CTRL, 32'(RATE_200MS) << CTRL_RATE);
    for (int c = CODE_CALC; c < CODE_CALC + 4; c++)
      apb(1'b1, OFS_ADD_CH, 32'(c));
    rd(OFS_STATUS, 32'h0f00_0000, st(MAX_CHANNELS, 0, 0, 0));
    apb(1'b1, OFS_CTRL, 32'h1 << CTRL_CLEAR_CHANNELS);
    rd(OFS_STATUS, 32'h0f00_0000, 32'h0);
    apb(1'b1, OFS_ADD_CH, 32'h0);
    apb(1'b1, OFS_ADD_CH, 32'(CODE_DIN));
    apb(1'b1, OFS_LENGTH, 32'(LEN));
    apb(1'b1, OFS_IRQ_STATUS, 32'hf);
    apb(1'b1, OFS_IRQ_MASK, 32'h5);
    apb(1'b1, OFS_CTRL, 32'h1);
    rd(OFS_STATUS, '1, st(2, MAXR, 0, 1));
    rd(OFS_LEN_LIMIT, '1, 32'(LIM));
    $display("test channels done");
    repeat (40) @(posedge clk);
    apb(1'b1, OFS_CTRL, 32'h101);
    rd(OFS_STATUS, 32'h3, 32'h2);
    wait (irq === 1'b1);
    rd(OFS_STATUS, 32'h1f00, st(0, 0, 1, 0));
    apb(1'b1, OFS_READ_SEL, 32'h0);
    rd(OFS_READ_DATA, '1, 32'h5a3c);
    apb(1'b1, OFS_READ_SEL, 32'h1 << SEL_IDX_LSB);
    rd(OFS_READ_DATA, '1, 32'h03a5);
    // Stamp reads need a word index inside the record
    apb(1'b0, OFS_READ_STAMP, 32'h0);
    stamp = rdv;
    chk("stamp present", 32'h1, 32'(stamp != 32'h0));
    apb(1'b1, OFS_READ_SEL, 32'(2 * NEED) << SEL_IDX_LSB);
    rd(OFS_READ_DATA, '1, 32'h0);
    apb(1'b1, OFS_IRQ_STATUS, 32'hf);
    stageEn <= 8'h01;
    rd(OFS_STATUS, 32'h1f00, 32'h0);
    rd(OFS_IRQ_STATUS, 32'h8, 32'h8);
    $display("test manual done");
    apb(1'b1, OFS_TRIG_MASK, '1);
    for (int i = 0; i < 5; i++)
    begin
      repeat (40) @(posedge clk);
      trig <= fcu_trig_s'(32'h1 << srcBit[i]);
      wait (irq === 1'b1);
      rd(OFS_IRQ_STATUS, 32'h5, (i < MAXR) ? 32'h1 : 32'h4);
      apb(1'b1, OFS_IRQ_STATUS, 32'hf);
      trig <= '0;
    end
    rd(OFS_STATUS, '1, st(2, MAXR, MAXR, 3));
    apb(1'b1, OFS_CTRL, 32'h3);
    // Leaving full passes through one inactive cycle before arming
    repeat (2) @(posedge clk);
    rd(OFS_STATUS, 32'h1f03, st(0, 0, MAXR - 1, 1));
    repeat (40) @(posedge clk);
    apb(1'b1, OFS_CTRL, 32'h103);
    wait (irq === 1'b1);
    // Overwrite re-arms at once and drops the oldest, so the newest sits one below
    apb(1'b1, OFS_READ_SEL, 32'(MAXR - 2));
    apb(1'b0, OFS_READ_STAMP, 32'h0);
    chk("newest stamp later", 32'h1, 32'(rdv > stamp));
    rd(OFS_STATUS, 32'h1f00, st(0, 0, MAXR - 1, 0));
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    @(posedge clk);
    chk("irq after masking", 32'h0, 32'(irq));
    $display("test triggers done");
    // At the 20 ms rate a measured channel records the rms source
    apb(1'b1, OFS_IRQ_STATUS, 32'hf);
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    apb(1'b1, OFS_CTRL, (32'(RATE_20MS) << CTRL_RATE) | 32'h1);
    apb(1'b1, OFS_CTRL, (32'(RATE_20MS) << CTRL_RATE) | 32'h101);
    wait (irq === 1'b1);
    apb(1'b1, OFS_READ_SEL, 32'h0);
    rd(OFS_READ_DATA, '1, 32'h1e0f);
    $display("test rates done");
    summarize();
  end
endmodule : fcu_fault_capture_unit_bench

bind fcu_fault_capture_unit fcu_capture_checker i_chk (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire
